//--- supervisor_watchdog_interrupt_tb_top.sv
`timescale 1ns/1ps
module supervisor_watchdog_interrupt_tb_top;
  import swdi_pkg::*;
  // short counts keep the run brief
  localparam swdi_cnt_t RST_P = 24'h000004;
  localparam swdi_cnt_t SU_P = 24'h000040;
  localparam swdi_cnt_t REL_P = 24'h000003;
  localparam swdi_periods_t WINP = {24'h90, 24'h80, 24'h70, 24'h60, 24'h50, 24'h40, 24'h30, 24'h20};
  localparam swdi_periods_t TOP = {24'hf0, 24'he0, 24'hc0, 24'ha0, 24'h80, 24'h70, 24'h60, 24'h40};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic uv = 1'b0;
  logic normal_mode = 1'b0;
  logic standby_mode = 1'b0;
  swdi_grp_t events = '0;
  swdi_grp_t flags = '0;
  swdi_req_t req;
  swdi_byte_t rdata;
  swdi_byte_t rd_v;
  logic rst_out_n;
  logic irq_out_n;
  logic sleep_req;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int m;

  always #10 clk = ~clk;

  swdi_top #(.RST_PULSE_CYC(RST_P), .STARTUP_CYC(SU_P), .IRQ_REL_CYC(REL_P),
    .WIN_PERIODS(WINP), .TO_PERIODS(TOP)) dut_u (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata), .events(events), .flags(flags),
    .primary_regulator_supply_uv(uv), .normal_mode(normal_mode),
    .standby_mode(standby_mode), .rst_out_n(rst_out_n), .irq_out_n(irq_out_n),
    .sleep_req(sleep_req));

  swdi_host_model host_u (.clk(clk), .req(req), .rdata(rdata));

  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk_byte(input string nm, input swdi_byte_t e, input swdi_byte_t g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic rd_chk(input swdi_addr_t a, input swdi_byte_t e, input string nm);
    host_u.reg_rd(a, rd_v);
    chk_byte(nm, e, rd_v);
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    host_u.reg_rd(ADDR_RST_REASON, rd_v);
  endtask

  task automatic pulse_ev(input swdi_grp_t e);
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= '0;
  endtask

  // n: edges until the reset pin falls, m: edges it stays low
  task automatic wait_rst(output int nn, output int mm);
    nn = 0;
    mm = 0;
    // let the edge that may have launched the pulse settle first
    #1;
    while (rst_out_n === 1'b1 && nn < 2000) begin
      @(posedge clk);
      #1;
      nn++;
    end
    while (rst_out_n === 1'b0 && mm < 100) begin
      @(posedge clk);
      #1;
      mm++;
    end
  endtask

  task automatic t_reset();
    rd_chk(ADDR_RST_REASON, RSN_RESET_VAL, "reason_srst");
    rd_chk(ADDR_RST_REASON, 8'h00, "reason_cleared");
    rd_chk(ADDR_WD_STATUS, 8'h00, "status_startup");
    rd_chk(5'h1f, 8'h00, "unmapped");
    chk_byte("irq_idle", 8'h01, {7'h00, irq_out_n});
  endtask

  task automatic t_early();
    do_reset();
    host_u.kick();
    rd_chk(ADDR_WD_STATUS, 8'h02, "status_window");
    pulse_ev('{bus: 8'h01, temp: 8'h00, sup: 8'h00});
    host_u.kick();
    wait_rst(n, m);
    chk_int("rst_pulse", RST_P, m);
    rd_chk(ADDR_RST_REASON, 8'h02, "reason_early");
    rd_chk(ADDR_WD_STATUS, 8'h00, "status_back");
    rd_chk(ADDR_IRQ_TOP, 8'h00, "irq_reset_clr");
  endtask

  // an early period change would leave the 32-cycle period in force
  task automatic t_window();
    do_reset();
    host_u.kick();
    repeat (24) @(posedge clk);
    host_u.set_period(3'h1);
    host_u.kick();
    // a write just after the trigger hits the closed window and must be dropped
    host_u.set_period(3'h2);
    rd_chk(ADDR_WD_CFG, 8'h01, "period_locked");
    wait_rst(n, m);
    // four cycles went to the dropped write and its read-back
    chk_int("late_delay", 1, int'(n + 4 >= WINP[1] - 1 && n + 4 <= WINP[1] + 1));
    rd_chk(ADDR_RST_REASON, 8'h04, "reason_late");
  endtask

  task automatic t_timeout();
    do_reset();
    @(posedge clk);
    standby_mode <= 1'b1;
    host_u.kick();
    rd_chk(ADDR_WD_STATUS, 8'h04, "status_tout");
    host_u.kick();
    wait_rst(n, m);
    chk_int("tout_delay", 1, int'(n >= TOP[0] - 1 && n <= TOP[0] + 1));
    rd_chk(ADDR_RST_REASON, 8'h08, "reason_tout");
    rd_chk(ADDR_WD_STATUS, 8'h00, "status_back");
    host_u.kick();
    @(posedge clk);
    normal_mode <= 1'b1;
    rd_chk(ADDR_WD_STATUS, 8'h02, "status_normal");
    @(posedge clk);
    normal_mode <= 1'b0;
    standby_mode <= 1'b0;
  endtask

  task automatic t_sleep();
    logic prev;
    do_reset();
    prev = 1'b1;
    m = 0;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (prev === 1'b1 && rst_out_n === 1'b0) m++;
      prev = rst_out_n;
    end
    chk_int("startup_resets", 2, m);
    chk_byte("sleep", 8'h01, {7'h00, sleep_req});
    rd_chk(ADDR_RST_REASON, 8'h01, "reason_startup");
    rd_chk(ADDR_WD_STATUS, 8'h17, "status_sleep");
  endtask

  task automatic t_uv();
    do_reset();
    @(posedge clk);
    uv <= 1'b1;
    m = 0;
    repeat (150) begin
      @(posedge clk);
      #1;
      if (rst_out_n !== 1'b1) m++;
    end
    host_u.kick();
    rd_chk(ADDR_WD_STATUS, 8'h00, "uv_status");
    chk_int("uv_resets", 0, m);
    @(posedge clk);
    uv <= 1'b0;
  endtask

  task automatic t_irq();
    do_reset();
    pulse_ev('{bus: 8'h01, temp: 8'h00, sup: 8'h00});
    @(posedge clk);
    #1;
    chk_byte("irq_low", 8'h00, {7'h00, irq_out_n});
    rd_chk(ADDR_IRQ_TOP, 8'h01, "irq_top_bus");
    rd_chk(ADDR_IRQ_BUS, 8'h01, "irq_bus");
    host_u.irq_clear(ADDR_IRQ_BUS, 8'h00);
    rd_chk(ADDR_IRQ_BUS, 8'h01, "w0_keeps");
    fork
      host_u.irq_clear(ADDR_IRQ_BUS, 8'h01);
      pulse_ev('{bus: 8'h00, temp: 8'h80, sup: 8'h02});
    join
    #1;
    n = 0;
    while (irq_out_n === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk_int("irq_gap", REL_P, n);
    rd_chk(ADDR_IRQ_SUP, 8'h02, "irq_kept");
    rd_chk(ADDR_IRQ_TEMP, 8'h80, "irq_temp");
    rd_chk(ADDR_IRQ_TOP, 8'h06, "irq_top_sup");
    rd_chk(ADDR_IRQ_BUS, 8'h00, "irq_bus_clr");
    host_u.irq_clear(ADDR_IRQ_SUP, 8'h02);
    host_u.irq_clear(ADDR_IRQ_TEMP, 8'h80);
    repeat (6) @(posedge clk);
    #1;
    chk_byte("irq_released", 8'h01, {7'h00, irq_out_n});
  endtask

  task automatic t_flags();
    @(posedge clk);
    flags <= '{bus: 8'h5a, temp: 8'h3c, sup: 8'ha5};
    rd_chk(ADDR_FLAG_BUS, 8'h5a, "flag_bus");
    rd_chk(ADDR_FLAG_TEMP, 8'h3c, "flag_temp");
    rd_chk(ADDR_FLAG_SUP, 8'ha5, "flag_sup");
    @(posedge clk);
    flags <= '{bus: 8'hc3, temp: 8'h00, sup: 8'h00};
    rd_chk(ADDR_FLAG_BUS, 8'hc3, "flag_live");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_early();
    t_window();
    t_timeout();
    t_sleep();
    t_uv();
    t_irq();
    t_flags();
    tally_and_finish();
  end
endmodule

//--- swdi_host_model.sv
`timescale 1ns/1ps
module swdi_host_model (
  // clock
  input wire logic clk,
  // register port
  output swdi_pkg::swdi_req_t req,
  input wire swdi_pkg::swdi_byte_t rdata
);
  import swdi_pkg::*;

  initial req = '0;

  // idle address and data are inverted so that a stale value is never read as fresh
  task automatic reg_wr(input swdi_addr_t a, input swdi_byte_t d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input swdi_addr_t a, output swdi_byte_t d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask

  task automatic kick();
    reg_wr(ADDR_WD_TRIG, 8'ha5);
  endtask

  // caller opens the valid window first
  task automatic set_period(input logic [2:0] sel);
    reg_wr(ADDR_WD_CFG, {5'h00, sel});
  endtask

  task automatic irq_clear(input swdi_addr_t a, input swdi_byte_t m);
    reg_wr(a, m);
  endtask
endmodule

//--- swdi_pkg.sv
package swdi_pkg;

  typedef logic [23:0] swdi_cnt_t;
  typedef logic [4:0] swdi_addr_t;
  typedef logic [7:0] swdi_byte_t;
  typedef swdi_cnt_t [7:0] swdi_periods_t;

  // one register-port access
  typedef struct packed {
    swdi_addr_t addr;
    swdi_byte_t wdata;
    logic wr;
    logic rd;
  } swdi_req_t;

  // one byte for each interrupt region, also used for the live flags
  typedef struct packed {
    swdi_byte_t bus;
    swdi_byte_t temp;
    swdi_byte_t sup;
  } swdi_grp_t;

  typedef enum logic [1:0] {
    WD_STARTUP = 2'b00,
    WD_WINDOW = 2'b01,
    WD_TIMEOUT = 2'b10,
    WD_SLEEP = 2'b11
  } swdi_wd_mode_t;

  // register map
  localparam swdi_addr_t ADDR_WD_TRIG = 5'h00;
  localparam swdi_addr_t ADDR_WD_CFG = 5'h01;
  localparam swdi_addr_t ADDR_IRQ_TOP = 5'h02;
  localparam swdi_addr_t ADDR_IRQ_BUS = 5'h03;
  localparam swdi_addr_t ADDR_IRQ_TEMP = 5'h04;
  localparam swdi_addr_t ADDR_IRQ_SUP = 5'h05;
  localparam swdi_addr_t ADDR_FLAG_BUS = 5'h06;
  localparam swdi_addr_t ADDR_FLAG_TEMP = 5'h07;
  localparam swdi_addr_t ADDR_FLAG_SUP = 5'h08;
  localparam swdi_addr_t ADDR_RST_REASON = 5'h09;
  localparam swdi_addr_t ADDR_WD_STATUS = 5'h0a;

  // reset-reason bit positions
  localparam int RSN_INIT = 0;
  localparam int RSN_EARLY = 1;
  localparam int RSN_LATE = 2;
  localparam int RSN_TOUT = 3;
  localparam int RSN_SYS = 4;

  localparam swdi_byte_t RSN_RESET_VAL = 8'h10;
  localparam logic [2:0] PSEL_RESET_VAL = 3'h0;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
  localparam swdi_cnt_t CNT_ONE = 24'h000001;

  // default timings in cycles of the 50 MHz clock
  localparam swdi_cnt_t RST_PULSE_CYC_DEF = 24'h0003e8;
  localparam swdi_cnt_t STARTUP_CYC_DEF = 24'h0f4240;
  localparam swdi_cnt_t IRQ_REL_CYC_DEF = 24'h000032;
  localparam swdi_periods_t WIN_PERIODS_DEF = {
    24'h4c4b40, 24'h3d0900, 24'h2dc6c0, 24'h1e8480,
    24'h186a00, 24'h0f4240, 24'h07a120, 24'h03d090
  };
  localparam swdi_periods_t TO_PERIODS_DEF = {
    24'hf42400, 24'hb71b00, 24'h7a1200, 24'h4c4b40,
    24'h2dc6c0, 24'h1e8480, 24'h0f4240, 24'h07a120
  };

endpackage

//--- swdi_top.sv
// Summary of operation
// - after reset release the watchdog runs start-up mode; a miss forces another reset
// - three start-up misses in a row send the system to sleep, no reset
// - entering normal mode after start-up switches the watchdog to window mode
// - window period is one of eight values chosen by a register write
// - a period change is accepted only while a valid trigger window is open
// - a trigger inside the valid window restarts the timer at zero
// - valid window runs from half the period to the full period
// - early or missing window trigger asserts reset at once, back to start-up
// - while the primary regulator is undervoltage the timer is held disabled
// - standby runs time-out mode; a trigger is valid anywhere in the period
// - no trigger before time-out period expiry asserts reset, back to start-up
// - interrupt pin is low whenever any interrupt bit is set and no release time is running
// - interrupt bits clear by source clear, and all clear during system reset
// - after a clear the interrupt pin stays high for the release time
// - writing one clears an interrupt bit, writing zero leaves it
// - a top-level register names the region, region registers the event
// - an event arriving during a read or clear is kept
// - bus, temperature and supply flag registers show live flags
// - each reset pin assertion records its cause in the reason register
// - reading the reason register clears it
`timescale 1ns/1ps
module swdi_top #(
  parameter swdi_pkg::swdi_cnt_t RST_PULSE_CYC = swdi_pkg::RST_PULSE_CYC_DEF,
  parameter swdi_pkg::swdi_cnt_t STARTUP_CYC = swdi_pkg::STARTUP_CYC_DEF,
  parameter swdi_pkg::swdi_cnt_t IRQ_REL_CYC = swdi_pkg::IRQ_REL_CYC_DEF,
  parameter swdi_pkg::swdi_periods_t WIN_PERIODS = swdi_pkg::WIN_PERIODS_DEF,
  parameter swdi_pkg::swdi_periods_t TO_PERIODS = swdi_pkg::TO_PERIODS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire swdi_pkg::swdi_req_t req,
  output swdi_pkg::swdi_byte_t rdata,
  // events and live flags
  input wire swdi_pkg::swdi_grp_t events,
  input wire swdi_pkg::swdi_grp_t flags,
  input wire logic primary_regulator_supply_uv,
  // operating mode
  input wire logic normal_mode,
  input wire logic standby_mode,
  // pins
  output logic rst_out_n,
  output logic irq_out_n,
  output logic sleep_req
);
  import swdi_pkg::*;

  function automatic logic hit(input swdi_addr_t a, input swdi_addr_t off);
    return a == off;
  endfunction

  function automatic swdi_byte_t w1c(input swdi_req_t r, input swdi_addr_t off);
    return (r.wr && hit(r.addr, off)) ? r.wdata : 8'h00;
  endfunction

  function automatic swdi_cnt_t period_of(input swdi_wd_mode_t m, input logic [2:0] sel);
    case (m)
      WD_STARTUP: return STARTUP_CYC;
      WD_TIMEOUT: return TO_PERIODS[sel];
      default: return WIN_PERIODS[sel];
    endcase
  endfunction

  swdi_wd_mode_t mode_q;
  swdi_cnt_t cnt_q;
  swdi_cnt_t rst_cnt_q;
  swdi_cnt_t rel_cnt_q;
  swdi_cnt_t rel_cnt_d;
  swdi_cnt_t period;
  swdi_cnt_t half;
  logic [2:0] psel_q;
  logic [1:0] attempts_q;
  logic rst_n_q;
  logic irq_n_q;
  logic sleep_q;
  logic normal_d1_q;
  logic standby_d1_q;
  swdi_grp_t irq_q;
  swdi_grp_t irq_d;
  swdi_grp_t clr;
  swdi_byte_t reason_q;
  swdi_byte_t reason_set;
  swdi_byte_t rd_val;
  swdi_byte_t rdata_q;
  logic trig;
  logic wd_run;
  logic window_open;
  logic trig_ok;
  logic early;
  logic expire;
  logic startup_miss;
  logic go_sleep;
  logic fault;
  logic normal_rise;
  logic standby_rise;
  logic cleared_any;
  logic [2:0] irq_top;

  assign rdata = rdata_q;
  assign rst_out_n = rst_n_q;
  assign irq_out_n = irq_n_q;
  assign sleep_req = sleep_q;

  // watchdog decisions
  assign trig = req.wr && hit(req.addr, ADDR_WD_TRIG);
  assign period = period_of(mode_q, psel_q);
  assign half = period >> 1;
  assign wd_run = rst_n_q && !primary_regulator_supply_uv && (mode_q != WD_SLEEP);
  // start-up and time-out accept a trigger anywhere in the period
  assign window_open = (mode_q == WD_WINDOW) ? (cnt_q >= half) : 1'b1;
  assign trig_ok = wd_run && trig && window_open;
  assign early = wd_run && trig && !window_open;
  // a shorter period written late in the window must still expire, hence not an equality
  assign expire = wd_run && !trig && (cnt_q >= period - CNT_ONE);
  assign startup_miss = expire && (mode_q == WD_STARTUP);
  assign go_sleep = startup_miss && (attempts_q == MAX_ATTEMPTS - 2'h1);
  assign fault = early || (expire && !go_sleep);
  assign normal_rise = normal_mode && !normal_d1_q;
  assign standby_rise = standby_mode && !standby_d1_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      normal_d1_q <= 1'b0;
      standby_d1_q <= 1'b0;
    end else begin
      normal_d1_q <= normal_mode;
      standby_d1_q <= standby_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= WD_STARTUP;
      cnt_q <= '0;
    end else if (go_sleep) begin
      mode_q <= WD_SLEEP;
      cnt_q <= '0;
    end else if (fault) begin
      mode_q <= WD_STARTUP;
      cnt_q <= '0;
    end else if (!wd_run) begin
      cnt_q <= '0;
    end else if (trig_ok) begin
      cnt_q <= '0;
      if (mode_q == WD_STARTUP) begin
        mode_q <= standby_mode ? WD_TIMEOUT : WD_WINDOW;
      end
    end else if ((mode_q != WD_STARTUP) && normal_rise) begin
      mode_q <= WD_WINDOW;
      cnt_q <= '0;
    end else if ((mode_q != WD_STARTUP) && standby_rise) begin
      mode_q <= WD_TIMEOUT;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      attempts_q <= 2'h0;
    end else if (trig_ok && (mode_q == WD_STARTUP)) begin
      attempts_q <= 2'h0;
    end else if (startup_miss && !go_sleep) begin
      attempts_q <= attempts_q + 2'h1;
    end
  end

  // a period written outside the open window is dropped silently
  always_ff @(posedge clk) begin
    if (srst) begin
      psel_q <= PSEL_RESET_VAL;
    end else if (req.wr && hit(req.addr, ADDR_WD_CFG) && wd_run && window_open) begin
      psel_q <= req.wdata[2:0];
    end
  end

  // reset pulse on the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_n_q <= 1'b1;
      rst_cnt_q <= '0;
    end else if (fault) begin
      rst_n_q <= 1'b0;
      rst_cnt_q <= RST_PULSE_CYC;
    end else if (!rst_n_q) begin
      rst_cnt_q <= rst_cnt_q - CNT_ONE;
      if (rst_cnt_q <= CNT_ONE) begin
        rst_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_q <= 1'b0;
    end else if (go_sleep) begin
      sleep_q <= 1'b1;
    end
  end

  // reset reason: a new cause wins over a clearing read
  always_comb begin
    reason_set = 8'h00;
    reason_set[RSN_INIT] = startup_miss && !go_sleep;
    reason_set[RSN_EARLY] = early;
    reason_set[RSN_LATE] = expire && (mode_q == WD_WINDOW);
    reason_set[RSN_TOUT] = expire && (mode_q == WD_TIMEOUT);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reason_q <= RSN_RESET_VAL;
    end else if (req.rd && hit(req.addr, ADDR_RST_REASON)) begin
      reason_q <= reason_set;
    end else begin
      reason_q <= reason_q | reason_set;
    end
  end

  // interrupt registers
  assign clr = {w1c(req, ADDR_IRQ_BUS), w1c(req, ADDR_IRQ_TEMP), w1c(req, ADDR_IRQ_SUP)};
  assign cleared_any = |(irq_q & clr);
  assign irq_top = {|irq_q.sup, |irq_q.temp, |irq_q.bus};

  always_comb begin
    if (!rst_n_q) begin
      irq_d = '0;
    end else begin
      irq_d = (irq_q & ~clr) | events;
    end
  end

  always_comb begin
    if (cleared_any) begin
      rel_cnt_d = IRQ_REL_CYC;
    end else if (rel_cnt_q != '0) begin
      rel_cnt_d = rel_cnt_q - CNT_ONE;
    end else begin
      rel_cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= '0;
      rel_cnt_q <= '0;
      irq_n_q <= 1'b1;
    end else begin
      irq_q <= irq_d;
      rel_cnt_q <= rel_cnt_d;
      // edge-sensitive hosts need the high gap to see a fresh falling edge
      irq_n_q <= (rel_cnt_d != '0) || !(|irq_d);
    end
  end

  // register read, data valid one cycle after the strobe
  always_comb begin
    case (req.addr)
      ADDR_WD_CFG: rd_val = {5'h00, psel_q};
      ADDR_IRQ_TOP: rd_val = {5'h00, irq_top};
      ADDR_IRQ_BUS: rd_val = irq_q.bus;
      ADDR_IRQ_TEMP: rd_val = irq_q.temp;
      ADDR_IRQ_SUP: rd_val = irq_q.sup;
      ADDR_FLAG_BUS: rd_val = flags.bus;
      ADDR_FLAG_TEMP: rd_val = flags.temp;
      ADDR_FLAG_SUP: rd_val = flags.sup;
      ADDR_RST_REASON: rd_val = reason_q;
      ADDR_WD_STATUS: rd_val = {3'h0, attempts_q, mode_q, sleep_q};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // checks
  sequence seq_early_trig;
    wd_run && trig && (mode_q == WD_WINDOW) && (cnt_q < half);
  endsequence

  sequence seq_late_miss;
    wd_run && !trig && (mode_q == WD_WINDOW) && (cnt_q >= period - CNT_ONE);
  endsequence

  sequence seq_reset_entry;
    !rst_n_q && (mode_q == WD_STARTUP) && (cnt_q == '0);
  endsequence

  chk_early_trig_reset: assert property (@(posedge clk) disable iff (srst)
    seq_early_trig |=> seq_reset_entry)
    else $error("early trigger did not reset");

  chk_late_trig_reset: assert property (@(posedge clk) disable iff (srst)
    seq_late_miss |=> seq_reset_entry)
    else $error("missed window did not reset");

  chk_trig_restart: assert property (@(posedge clk) disable iff (srst)
    (wd_run && trig && (cnt_q >= half) && (mode_q == WD_WINDOW)) |=> (cnt_q == '0) && rst_n_q)
    else $error("valid trigger did not restart timer");

  chk_uv_holds_timer: assert property (@(posedge clk) disable iff (srst)
    (primary_regulator_supply_uv && !go_sleep) |=> (cnt_q == '0))
    else $error("timer ran during undervoltage");

  chk_sleep_no_reset: assert property (@(posedge clk) disable iff (srst)
    go_sleep |=> sleep_q && rst_n_q && (mode_q == WD_SLEEP))
    else $error("third miss did not enter sleep");

  chk_reset_width: assert property (@(posedge clk) disable iff (srst)
    $rose(rst_n_q) |-> ($past(rst_cnt_q) == CNT_ONE))
    else $error("reset pulse width wrong");

  chk_irq_pin_low: assert property (@(posedge clk) disable iff (srst)
    ((rel_cnt_q == '0) && (|irq_q)) |-> !irq_n_q)
    else $error("pending interrupt not on pin");

  chk_release_gap: assert property (@(posedge clk) disable iff (srst)
    cleared_any |=> irq_n_q [*2])
    else $error("interrupt pin not released after clear");

  chk_irq_reset_clear: assert property (@(posedge clk) disable iff (srst)
    !rst_n_q |=> (irq_q == '0))
    else $error("interrupts kept during reset");

  chk_event_kept: assert property (@(posedge clk) disable iff (srst)
    (rst_n_q && (events.bus[0] || events.sup[0])) |=> (irq_q.bus[0] || irq_q.sup[0]))
    else $error("interrupt event lost");

  chk_reason_clear: assert property (@(posedge clk) disable iff (srst)
    (req.rd && hit(req.addr, ADDR_RST_REASON) && !fault && !startup_miss) |=> (reason_q == 8'h00))
    else $error("reason not cleared by read");

  chk_period_locked: assert property (@(posedge clk) disable iff (srst)
    (req.wr && hit(req.addr, ADDR_WD_CFG) && !window_open) |=> $stable(psel_q))
    else $error("period changed outside window");

endmodule
